/* File: rtl/ber_test_map.svh */
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 16-bit register port, word addressed
// Notes:   included by bare name
`ifndef BER_TEST_MAP_SVH
`define BER_TEST_MAP_SVH
`define SEND_POSITION_ADDR      12'h00c3
`define TRANSMIT_LENGTH_ADDR    12'h00c4
`define RECEIVE_LENGTH_ADDR     12'h00c5
`define RECEIVE_POSITION_ADDR   12'h00c6
`define ERROR_TALLY_ADDR        12'h00c7
`define REG_RESET_VALUE         16'h0000
`define STREAM_NARROW_HI        12
`define STREAM_NARROW_LO        8
`define STREAM_WIDE_LO          9
`define CHANNEL_NARROW_HI       7
`define CHANNEL_WIDE_HI         8
`define LENGTH_HI               8
`define TALLY_MAX               16'hffff
`define PRBS_SEED               15'h7fff
`define SYNC_RUN_BITS           5'h10
`endif

/* File: rtl/ber_test_pkg.sv */
// Purpose: shared types of the bit error rate tester
// Assumes: nothing beyond the map header
// Notes:   no constants here, only types
package ber_test_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_HUNT, RX_LOCKED} rx_state_type;
  typedef logic [14:0] prbs_type;
endpackage

/* File: rtl/ber_window_if.sv */
// Purpose: carries a channel window test between the top and its helpers
// Assumes: one clock domain
// Notes:   top fills the request side, helper returns the hit flag
`timescale 1ns/1ps
`default_nettype none
interface ber_window_if;
  logic [4:0] cur_stream;
  logic [8:0] cur_channel;
  logic [4:0] sel_stream;
  logic [8:0] sel_start;
  logic [8:0] sel_length;
  logic       hit;
  modport owner (output cur_stream, output cur_channel, output sel_stream,
                 output sel_start, output sel_length, input hit);
  modport judge (input cur_stream, input cur_channel, input sel_stream,
                 input sel_start, input sel_length, output hit);
endinterface
`default_nettype wire

/* File: rtl/ber_window_match.sv */
// Purpose: decides whether the current stream and channel lie in a test window
// Assumes: window does not wrap past the last channel of the frame
// Notes:   combinational
`timescale 1ns/1ps
`default_nettype none
module ber_window_match
(
  ber_window_if.judge win
);
  logic [9:0] offset;

  // channel distance from window start, borrow bit marks channels before it
  always_comb
  begin
    offset  = {1'b0, win.cur_channel} - {1'b0, win.sel_start};
    win.hit = (win.cur_stream == win.sel_stream) && !offset[9]
              && (offset[8:0] <= win.sel_length);
  end
endmodule
`default_nettype wire

/* File: rtl/local_port_ber_tester.sv */
// Purpose: bit error rate send and compare for the local serial port
// Assumes: i_bit_strobe marks each serial bit slot, with stream and channel given
// Notes:   registers are reached over a 16-bit word-addressed port
// Overview of operation
// - narrow mode: send stream in bits 12:8, start channel in bits 7:0
// - fast mode: send stream in bits 12:9, start channel in bits 8:0
// - narrow mode: receive stream in bits 12:8, start channel in bits 7:0
// - fast mode: receive stream in bits 12:9, start channel in bits 8:0
// - send test pattern over transmit length plus one channels each frame
// - compare test pattern over receive length plus one channels each frame
// - error tally is read-only in bits 15:0, writes ignored
// - tally saturates at ffff and holds until the clear bit
// - tally counts each compared bit that differs from the expected pattern, only once the receiver is locked
// - every field resets to zero
// - fast mode bit limits send and compare windows to streams 0 to 15; other streams still carry switch data
`timescale 1ns/1ps
`default_nettype none
`include "ber_test_map.svh"
module local_port_ber_tester
(
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  // register port
  input  wire logic [11:0] i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [15:0] i_reg_wdata,
  output logic      [15:0] o_reg_rdata,
  // mode and clear controls from the device control registers
  input  wire logic        i_local_fast_rate_select,
  input  wire logic        i_local_error_count_clear,
  // frame timing
  input  wire logic        i_bit_strobe,
  input  wire logic [4:0]  i_stream,
  input  wire logic [8:0]  i_channel,
  // serial data paths
  input  wire logic        i_switch_out_bit,
  input  wire logic        i_line_in_bit,
  output logic             o_line_out_bit,
  output logic             o_tx_active,
  output logic             o_rx_locked
);
  typedef struct packed {
    logic [15:0]                      send_pos;
    logic [15:0]                      tx_len;
    logic [15:0]                      rx_len;
    logic [15:0]                      recv_pos;
    logic [15:0]                      tally;
    logic [15:0]                      rdata;
    ber_test_pkg::prbs_type           tx_prbs;
    ber_test_pkg::prbs_type           rx_prbs;
    ber_test_pkg::rx_state_type       rx_state;
    logic [4:0]                       sync_run;
    logic                             out_bit;
    logic                             tx_active;
    logic                             locked;
  } state_type;

  state_type st_q;
  state_type st_d;

  ber_window_if tx_win();
  ber_window_if rx_win();

  ber_window_match u_tx_match
  (
    .win (tx_win)
  );

  ber_window_match u_rx_match
  (
    .win (rx_win)
  );

  // next pattern state, x^15 + x^14 + 1
  function automatic ber_test_pkg::prbs_type prbs_step(input ber_test_pkg::prbs_type p);
    prbs_step = {p[13:0], p[14] ^ p[13]};
  endfunction

  // stream field per rate mode
  function automatic logic [4:0] stream_of(input logic [15:0] r, input logic fast);
    if (fast)
      stream_of = {1'b0, r[`STREAM_NARROW_HI:`STREAM_WIDE_LO]};
    else
      stream_of = r[`STREAM_NARROW_HI:`STREAM_NARROW_LO];
  endfunction

  // channel field per rate mode
  function automatic logic [8:0] channel_of(input logic [15:0] r, input logic fast);
    if (fast)
      channel_of = r[`CHANNEL_WIDE_HI:0];
    else
      channel_of = {1'b0, r[`CHANNEL_NARROW_HI:0]};
  endfunction

  // window requests; fast mode only covers streams 0 to 15
  always_comb
  begin
    tx_win.cur_stream  = i_stream;
    tx_win.cur_channel = i_channel;
    tx_win.sel_stream  = stream_of(st_q.send_pos, i_local_fast_rate_select);
    tx_win.sel_start   = channel_of(st_q.send_pos, i_local_fast_rate_select);
    tx_win.sel_length  = st_q.tx_len[`LENGTH_HI:0];
    rx_win.cur_stream  = i_stream;
    rx_win.cur_channel = i_channel;
    rx_win.sel_stream  = stream_of(st_q.recv_pos, i_local_fast_rate_select);
    rx_win.sel_start   = channel_of(st_q.recv_pos, i_local_fast_rate_select);
    rx_win.sel_length  = st_q.rx_len[`LENGTH_HI:0];
  end

  logic unused_stream_ok;
  logic tx_hit;
  logic rx_hit;
  logic expect_bit;
  logic mismatch;

  // fast mode keeps streams 16 to 31 out of send and compare; switch data still passes out on them
  always_comb
  begin
    unused_stream_ok = !i_local_fast_rate_select || !i_stream[4];
    tx_hit     = tx_win.hit && unused_stream_ok;
    rx_hit     = rx_win.hit && unused_stream_ok;
    expect_bit = st_q.rx_prbs[14] ^ st_q.rx_prbs[13];
    mismatch   = i_line_in_bit != expect_bit;
  end

  // whole block next state
  always_comb
  begin
    st_d = st_q;
    // register writes; tally address takes no write
    if (i_reg_wr)
    begin
      unique case (i_reg_addr)
        `SEND_POSITION_ADDR:    st_d.send_pos = i_reg_wdata;
        `TRANSMIT_LENGTH_ADDR:  st_d.tx_len   = i_reg_wdata;
        `RECEIVE_LENGTH_ADDR:   st_d.rx_len   = i_reg_wdata;
        `RECEIVE_POSITION_ADDR: st_d.recv_pos = i_reg_wdata;
        default:                st_d.rdata    = st_q.rdata;
      endcase
    end
    // reads return one cycle later; unmapped reads zero
    if (i_reg_rd)
    begin
      unique case (i_reg_addr)
        `SEND_POSITION_ADDR:    st_d.rdata = st_q.send_pos;
        `TRANSMIT_LENGTH_ADDR:  st_d.rdata = st_q.tx_len;
        `RECEIVE_LENGTH_ADDR:   st_d.rdata = st_q.rx_len;
        `RECEIVE_POSITION_ADDR: st_d.rdata = st_q.recv_pos;
        `ERROR_TALLY_ADDR:      st_d.rdata = st_q.tally;
        default:                st_d.rdata = `REG_RESET_VALUE;
      endcase
    end
    // output path: pattern only inside the window, switch data elsewhere
    if (i_bit_strobe)
    begin
      st_d.tx_active = tx_hit;
      if (tx_hit)
      begin
        st_d.out_bit = st_q.tx_prbs[14] ^ st_q.tx_prbs[13];
        st_d.tx_prbs = prbs_step(st_q.tx_prbs);
      end
      else
        st_d.out_bit = i_switch_out_bit;
    end
    // receiver: load incoming bits while hunting, count only once locked
    if (i_bit_strobe && rx_hit)
    begin
      unique case (st_q.rx_state)
        ber_test_pkg::RX_IDLE, ber_test_pkg::RX_HUNT:
        begin
          // self-synchronise by shifting in received bits
          st_d.rx_prbs  = {st_q.rx_prbs[13:0], i_line_in_bit};
          st_d.rx_state = ber_test_pkg::RX_HUNT;
          if (st_q.rx_state == ber_test_pkg::RX_HUNT && !mismatch)
          begin
            st_d.sync_run = st_q.sync_run + 5'h01;
            if (st_q.sync_run == `SYNC_RUN_BITS)
            begin
              st_d.rx_state = ber_test_pkg::RX_LOCKED;
              st_d.locked   = 1'b1;
            end
          end
          else
            st_d.sync_run = 5'h00;
        end
        ber_test_pkg::RX_LOCKED:
        begin
          st_d.rx_prbs = prbs_step(st_q.rx_prbs);
          // saturate rather than wrap so a long run never looks clean
          if (mismatch && st_q.tally != `TALLY_MAX)
            st_d.tally = st_q.tally + 16'h0001;
        end
      endcase
    end
    // clear wins only for the tally it empties; an error in the same cycle is lost
    if (i_local_error_count_clear)
      st_d.tally = `REG_RESET_VALUE;
  end

  // single state register
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_q           <= '0;
      st_q.tx_prbs   <= `PRBS_SEED;
      st_q.rx_prbs   <= `PRBS_SEED;
      st_q.rx_state  <= ber_test_pkg::RX_IDLE;
    end
    else
      st_q <= st_d;
  end

  // outputs straight from flip-flops
  always_comb
  begin
    o_reg_rdata    = st_q.rdata;
    o_line_out_bit = st_q.out_bit;
    o_tx_active    = st_q.tx_active;
    o_rx_locked    = st_q.locked;                                 // own flop, no decode
  end
endmodule
`default_nettype wire

/* File: test/ber_far_end_model.sv */
// Purpose: far end sending the test sequence to the line input
// Assumes: one sequence bit per compared slot
// Notes:   i_flip spoils the current bit only
`timescale 1ns/1ps
`default_nettype none
module ber_far_end_model
(
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_resetn,
  // slot control
  input  wire logic i_step,
  input  wire logic i_flip,
  // line toward the tester
  output logic      o_bit
);
  logic [14:0] seq_q;
  // same x^15+x^14+1 sequence; phase is free since the receiver locks itself
  always_ff @(posedge i_sys_clk or negedge i_resetn)
    if (!i_resetn)
      seq_q <= 15'h7fff;
    else if (i_step)
      seq_q <= {seq_q[13:0], seq_q[14] ^ seq_q[13]};
  assign o_bit = seq_q[14] ^ i_flip;
endmodule
`default_nettype wire

/* File: test/local_port_ber_tester_bench.sv */
// Purpose: self-checking bench of the bit error rate tester
// Assumes: one slot every two clocks
// Notes:   far end model feeds the line input
`timescale 1ns/1ps
`default_nettype none
`include "ber_test_map.svh"
module local_port_ber_tester_bench;
  logic        clk, resetn, wr, rd, fast, clr, stb, sw, flip, step, line_bit;
  logic        out_bit, tx_act, locked;
  logic [11:0] addr;
  logic [15:0] wdata, rdata;
  logic [4:0]  stream;
  logic [8:0]  chan;
  int          bad_count, comparisons;
  local_port_ber_tester dut (.i_sys_clk(clk), .i_resetn(resetn), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_local_fast_rate_select(fast), .i_local_error_count_clear(clr), .i_bit_strobe(stb),
    .i_stream(stream), .i_channel(chan), .i_switch_out_bit(sw), .i_line_in_bit(line_bit),
    .o_line_out_bit(out_bit), .o_tx_active(tx_act), .o_rx_locked(locked));
  ber_far_end_model far (.i_sys_clk(clk), .i_resetn(resetn), .i_step(step),
    .i_flip(flip), .o_bit(line_bit));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  // read data is valid just after the edge that takes the strobe
  task automatic expect_reg(input logic [11:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic slot(input logic [4:0] s, input logic [8:0] c, input logic f, input logic st);
    @(posedge clk);
    stream <= s;
    chan   <= c;
    flip   <= f;
    step   <= st;
    stb    <= 1'b1;
    @(posedge clk);
    stb    <= 1'b0;
    step   <= 1'b0;
    flip   <= 1'b0;
    #1;
  endtask
  task automatic reg_access();
    for (int a = 'h0c3; a <= 'h0c7; a++)
      expect_reg(a[11:0], 16'h0000);
    expect_reg(12'h0100, 16'h0000);
    wr_reg(`RECEIVE_POSITION_ADDR, 16'h1234);
    wr_reg(`ERROR_TALLY_ADDR, 16'h5a5a);
    expect_reg(`RECEIVE_POSITION_ADDR, 16'h1234);
    expect_reg(`ERROR_TALLY_ADDR, 16'h0000);
  endtask
  task automatic tx_window();
    sw <= 1'b1;
    wr_reg(`SEND_POSITION_ADDR, 16'h0305);
    wr_reg(`TRANSMIT_LENGTH_ADDR, 16'h0001);
    for (int c = 4; c < 8; c++)
    begin
      slot(5'h03, c[8:0], 1'b0, 1'b0);
      chk({15'h0000, tx_act}, {15'h0000, c == 5 || c == 6});
      if (!tx_act)
        chk({15'h0000, out_bit}, 16'h0001);
      else
        chk({15'h0000, out_bit}, 16'h0000);
    end
    slot(5'h04, 9'h005, 1'b0, 1'b0);
    chk({15'h0000, tx_act}, 16'h0000);
    fast <= 1'b1;
    wr_reg(`SEND_POSITION_ADDR, 16'h0605);
    wr_reg(`TRANSMIT_LENGTH_ADDR, 16'h0000);
    slot(5'h03, 9'h005, 1'b0, 1'b0);
    chk({15'h0000, tx_act}, 16'h0001);
    chk({15'h0000, out_bit}, 16'h0000);
    slot(5'h03, 9'h006, 1'b0, 1'b0);
    chk({15'h0000, tx_act}, 16'h0000);
    slot(5'h13, 9'h005, 1'b0, 1'b0);
    chk({15'h0000, tx_act}, 16'h0000);
    fast <= 1'b0;
  endtask
  task automatic rx_errors();
    wr_reg(`RECEIVE_POSITION_ADDR, 16'h0200);
    wr_reg(`RECEIVE_LENGTH_ADDR, 16'h0000);
    repeat (40) slot(5'h02, 9'h000, 1'b0, 1'b1);
    chk({15'h0000, locked}, 16'h0001);
    expect_reg(`ERROR_TALLY_ADDR, 16'h0000);
    repeat (3) slot(5'h02, 9'h000, 1'b1, 1'b1);
    slot(5'h02, 9'h001, 1'b1, 1'b0);
    slot(5'h05, 9'h000, 1'b1, 1'b0);
    repeat (4) slot(5'h02, 9'h000, 1'b0, 1'b1);
    expect_reg(`ERROR_TALLY_ADDR, 16'h0003);
    clr <= 1'b1;
    expect_reg(`ERROR_TALLY_ADDR, 16'h0000);
    clr <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog: the run needs well under a thousand cycles
  initial
  begin
    #50_000;
    bad_count++;
    print_verdict();
  end
  initial
  begin
    {resetn, wr, rd, fast, clr, stb, sw, flip, step} = 9'h000;
    addr = 12'h000;
    wdata = 16'h0000;
    stream = 5'h00;
    chan = 9'h000;
    bad_count = 0;
    comparisons = 0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    reg_access();
    tx_window();
    rx_errors();
    print_verdict();
  end
endmodule
`default_nettype wire

/* File: test/local_port_ber_tester_properties.sv */
// Purpose: port-level checks of the bit error rate tester
// Assumes: send window mirrored here from register writes
// Notes:   bound below
`timescale 1ns/1ps
`default_nettype none
`include "ber_test_map.svh"
module local_port_ber_tester_properties
(
  // clock and reset
  input wire logic        i_sys_clk,
  input wire logic        i_resetn,
  // register port
  input wire logic [11:0] i_reg_addr,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [15:0] o_reg_rdata,
  // controls and slot timing
  input wire logic        i_local_fast_rate_select,
  input wire logic        i_local_error_count_clear,
  input wire logic        i_bit_strobe,
  input wire logic [4:0]  i_stream,
  input wire logic [8:0]  i_channel,
  // serial path
  input wire logic        i_switch_out_bit,
  input wire logic        o_line_out_bit,
  input wire logic        o_tx_active,
  input wire logic        o_rx_locked
);
  logic [15:0] pos_q;
  logic [15:0] len_q;
  logic [9:0]  lo;
  logic [9:0]  hi;
  logic        hit;
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);
  // own copy of the window, so a stale design register shows up
  always_ff @(posedge i_sys_clk or negedge i_resetn)
    if (!i_resetn)
    begin
      pos_q <= `REG_RESET_VALUE;
      len_q <= `REG_RESET_VALUE;
    end
    else if (i_reg_wr && i_reg_addr == `SEND_POSITION_ADDR)
      pos_q <= i_reg_wdata;
    else if (i_reg_wr && i_reg_addr == `TRANSMIT_LENGTH_ADDR)
      len_q <= i_reg_wdata;
  // one spare bit so start plus length never wraps
  always_comb
  begin
    lo  = i_local_fast_rate_select ? {1'h0, pos_q[8:0]} : {2'h0, pos_q[7:0]};
    hi  = lo + {1'h0, len_q[8:0]};
    hit = (i_local_fast_rate_select ? i_stream == {1'h0, pos_q[12:9]}
                                    : i_stream == pos_q[12:8])
          && {1'h0, i_channel} >= lo && {1'h0, i_channel} <= hi;
  end
  a_send_window_hit: assert property (i_bit_strobe |=> o_tx_active == $past(hit))
    else $error("send window flag wrong");
  a_passthrough_bit: assert property (i_bit_strobe |=>
    o_tx_active || o_line_out_bit == $past(i_switch_out_bit)) else $error("bit not passed");
  a_fast_upper_streams: assert property (i_bit_strobe && i_local_fast_rate_select &&
    i_stream[4] |=> !o_tx_active) else $error("upper stream used");
  a_serial_out_holds: assert property (!i_bit_strobe |=>
    $stable(o_line_out_bit) && $stable(o_tx_active)) else $error("output moved");
  a_read_data_holds: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved");
  a_unmapped_reads_zero: assert property (i_reg_rd && (i_reg_addr < `SEND_POSITION_ADDR ||
    i_reg_addr > `ERROR_TALLY_ADDR) |=> o_reg_rdata == 16'h0000) else $error("unmapped read");
  a_lock_holds: assert property (o_rx_locked |=> o_rx_locked)
    else $error("lock lost");
  a_lock_on_strobe: assert property ($rose(o_rx_locked) |-> $past(i_bit_strobe))
    else $error("lock without slot");
  a_clear_reads_zero: assert property ($past(i_local_error_count_clear) &&
    i_local_error_count_clear && i_reg_rd && i_reg_addr == `ERROR_TALLY_ADDR
    |=> o_reg_rdata == 16'h0000) else $error("tally not cleared");
  c_tx_active: cover property (i_bit_strobe ##1 o_tx_active);
  c_locked: cover property ($rose(o_rx_locked));
  c_clear_read: cover property (i_local_error_count_clear && i_reg_rd);
endmodule
bind local_port_ber_tester local_port_ber_tester_properties chk (.i_sys_clk(i_sys_clk),
  .i_resetn(i_resetn), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .i_local_fast_rate_select(i_local_fast_rate_select),
  .i_local_error_count_clear(i_local_error_count_clear), .i_bit_strobe(i_bit_strobe),
  .i_stream(i_stream), .i_channel(i_channel), .i_switch_out_bit(i_switch_out_bit),
  .o_line_out_bit(o_line_out_bit), .o_tx_active(o_tx_active), .o_rx_locked(o_rx_locked));
`default_nettype wire
